// ==== common/spmg_consts.svh ====
// Register offsets, field positions, mode codes and timing counts
`ifndef SPMG_CONSTS_SVH
`define SPMG_CONSTS_SVH

`define SPMG_ADDR_W          8
`define SPMG_DATA_W          8
`define SPMG_OFF_SMC         8'h33
`define SPMG_OFF_PR_LOW      8'h64
`define SPMG_OFF_PR_HIGH     8'h65
`define SPMG_OFF_STATUS      8'h36

`define SPMG_SE_BIT          0
`define SPMG_SM_LSB          1
`define SPMG_SM_MSB          3
`define SPMG_RESET_BYTE      8'h00

`define SPMG_SM_IDLE         3'h0
`define SPMG_SM_PDOWN        3'h2
`define SPMG_SM_PSAVE        3'h3
`define SPMG_SM_STBY         3'h6
`define SPMG_SM_XSTBY        3'h7

`define SPMG_CNT_W           12
`define SPMG_STBY_WAKE_CK    12'h006
`define SPMG_HALT_EXTRA_CK   12'h004
`define SPMG_START_CK0       12'h010
`define SPMG_START_CK1       12'h040
`define SPMG_START_CK2       12'h100
`define SPMG_START_CK3       12'h400
`define SPMG_XTAL_FUSE_BIT   3

`define SPMG_NUM_PERIPH      16

`endif

// ==== common/spmg_pkg.sv ====
// Types shared by the sleep and power gating controller
package spmg_pkg;

    typedef enum logic [2:0] {
        SPMG_MODE_IDLE,
        SPMG_MODE_PDOWN,
        SPMG_MODE_PSAVE,
        SPMG_MODE_STBY,
        SPMG_MODE_XSTBY
    } spmg_mode_e;

    typedef enum logic [1:0] {
        SPMG_ST_ACTIVE,
        SPMG_ST_SLEEP,
        SPMG_ST_START,
        SPMG_ST_HOLD
    } spmg_state_e;

    typedef struct packed {
        logic       twi_addr_match;
        logic [3:0] upper_external_irqs;
        logic [3:0] upper_level_mode;
        logic [3:0] lower_external_irqs;
        logic       pin_change_irq;
        logic       usb_async_wakeup_irq;
        logic       wdt_irq;
        logic       any_enabled_irq;
    } spmg_wake_s;

    typedef struct packed {
        logic cpu;
        logic flash;
        logic io;
        logic osc;
    } spmg_clk_s;

endpackage : spmg_pkg

// ==== rtl/spmg_count.sv ====
// Loadable down counter used for start-up and halt delays
`timescale 1ns/100ps
`include "spmg_consts.svh"

module spmg_count #(
    parameter int W = `SPMG_CNT_W
) (
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    output logic              busy,
    output logic              done
);
    logic [W-1:0] cnt_q;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (load) begin
            cnt_q <= load_val;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - W'(1);
        end
    end

    assign busy = (cnt_q != '0);
    assign done = (cnt_q == W'(1)) && !load;

endmodule : spmg_count

// ==== rtl/spmg_top.sv ====
// Sleep mode sequencer, clock gating and power reduction registers
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/100ps
`include "spmg_consts.svh"

// Contract
// - Mode 010 with enable enters power-down
// - Power-down stops oscillator and all clocks
// - Interrupt logic, TWI, watchdog keep running
// - Only listed sources wake from power-down
// - Fuse-selected restart delay before wake
// - Mode 011 power-save equals power-down
// - Mode 110 standby, oscillator on, six cycles
// - Mode 111 extended standby like standby
// - Mode field bits 3:1, three reserved codes
// - Reduction bit stops clock, blocks access
// - Clearing bit restarts clock, state kept
// - Gating works in active and idle
// - Comparator off in non-idle sleep modes
// - Reference on only for detector or comparator
// - Brown-out and watchdog run in sleep
// - Input buffers off when I/O clock stops
// - Debug fuse keeps main clock running
// - Bits 7:4 read zero, reset zero
// - Halt sleeps only with enable bit set
// - Mode 000 idle stops CPU, flash
// - Wake halts four cycles past start-up
// - Reset during sleep wakes to vector
module spmg_top
    import spmg_pkg::*;
(
    input  wire logic                       sys_clk,
    input  wire logic                       rst_n,
    input  wire logic [`SPMG_ADDR_W-1:0]    reg_addr,
    input  wire logic [`SPMG_DATA_W-1:0]    reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic      [`SPMG_DATA_W-1:0]    reg_rdata,
    input  wire logic                       halt_exec,
    input  wire spmg_wake_s                 wake_in,
    input  wire logic [3:0]                 clock_source_fuses,
    input  wire logic [2:0]                 brownout_level_fuses,
    input  wire logic                       debug_enable_fuse,
    input  wire logic                       twi_enabled,
    input  wire logic                       wdt_enabled,
    input  wire logic                       acmp_enabled,
    input  wire logic                       acmp_uses_vref,
    input  wire logic                       wake_pins_armed,
    output spmg_clk_s                       clk_en,
    output logic [`SPMG_NUM_PERIPH-1:0]     periph_clk_en,
    output logic [`SPMG_NUM_PERIPH-1:0]     periph_io_en,
    output logic                            cpu_halted,
    output logic                            cpu_resume,
    output logic                            twi_run,
    output logic                            wdt_run,
    output logic                            ext_int_run,
    output logic                            bod_run,
    output logic                            acmp_run,
    output logic                            vref_en,
    output logic                            digital_in_en,
    output logic                            wake_in_en
);

    // Register state
    logic [2:0]  sleep_mode_select_q;
    logic        sleep_enable_bit_q;
    logic [7:0]  power_reduction_low_q;
    logic [7:0]  power_reduction_high_q;
    logic [`SPMG_DATA_W-1:0] rdata_q;

    // Sequencer state
    spmg_state_e state_q;
    spmg_state_e state_d;
    spmg_mode_e  mode_q;
    spmg_mode_e  mode_d;
    spmg_mode_e  mode_eff;
    spmg_clk_s   clk_q;
    spmg_clk_s   clk_d;
    logic        resume_q;

    // Decode and wake qualification
    logic        xtal_sel;
    logic        sleep_req;
    logic        deep_mode;
    logic        osc_kept;
    logic        wake_deep;
    logic        wake_any;
    logic [`SPMG_CNT_W-1:0] start_ck;
    logic        start_load;
    logic        start_busy;
    logic        start_done;
    logic        hold_load;
    logic        hold_done;
    logic [`SPMG_NUM_PERIPH-1:0] pr_bits;

    assign xtal_sel = clock_source_fuses[`SPMG_XTAL_FUSE_BIT];
    assign sleep_req = halt_exec && sleep_enable_bit_q;

    // Map the written field to a sleep mode
    always_comb begin
        unique case (sleep_mode_select_q)
            `SPMG_SM_IDLE:  mode_d = SPMG_MODE_IDLE;
            `SPMG_SM_PDOWN: mode_d = SPMG_MODE_PDOWN;
            `SPMG_SM_PSAVE: mode_d = SPMG_MODE_PSAVE;
            // Without a crystal the oscillator may not be left
            // unattended, so standby falls back to power-down.
            `SPMG_SM_STBY:
                mode_d = xtal_sel ? SPMG_MODE_STBY
                                  : SPMG_MODE_PDOWN;
            `SPMG_SM_XSTBY:
                mode_d = xtal_sel ? SPMG_MODE_XSTBY
                                  : SPMG_MODE_PSAVE;
            default:        mode_d = SPMG_MODE_IDLE;
        endcase
    end

    // At entry the new mode is not latched yet, so the enables for
    // that edge must see the decoded field itself.
    assign mode_eff  = (state_q == SPMG_ST_ACTIVE) ? mode_d : mode_q;
    assign deep_mode = (mode_eff != SPMG_MODE_IDLE);
    assign osc_kept  = (mode_eff == SPMG_MODE_STBY) ||
                       (mode_eff == SPMG_MODE_XSTBY);

    // Upper lines wake deep sleep only in level mode
    assign wake_deep = (wake_in.twi_addr_match && twi_enabled) ||
                       (|(wake_in.upper_external_irqs &
                          wake_in.upper_level_mode)) ||
                       (|wake_in.lower_external_irqs) ||
                       wake_in.pin_change_irq ||
                       wake_in.usb_async_wakeup_irq ||
                       (wake_in.wdt_irq && wdt_enabled);
    assign wake_any = deep_mode ? wake_deep
                                : (wake_deep || wake_in.any_enabled_irq);

    // Restart delay follows the same fuses as the reset time-out
    always_comb begin
        unique case (clock_source_fuses[1:0])
            2'h0:    start_ck = `SPMG_START_CK0;
            2'h1:    start_ck = `SPMG_START_CK1;
            2'h2:    start_ck = `SPMG_START_CK2;
            default: start_ck = `SPMG_START_CK3;
        endcase
    end

    // Sequencer
    always_comb begin
        state_d    = state_q;
        start_load = 1'b0;
        hold_load  = 1'b0;
        unique case (state_q)
            SPMG_ST_ACTIVE: begin
                if (sleep_req) begin
                    state_d = SPMG_ST_SLEEP;
                end
            end
            SPMG_ST_SLEEP: begin
                if (wake_any) begin
                    if (!deep_mode) begin
                        state_d   = SPMG_ST_HOLD;
                        hold_load = 1'b1;
                    end else begin
                        state_d    = SPMG_ST_START;
                        start_load = 1'b1;
                    end
                end
            end
            SPMG_ST_START: begin
                if (start_done) begin
                    state_d   = SPMG_ST_HOLD;
                    hold_load = 1'b1;
                end
            end
            SPMG_ST_HOLD: begin
                if (hold_done) begin
                    state_d = SPMG_ST_ACTIVE;
                end
            end
        endcase
    end

    // Reset from any state returns straight to execution
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_q <= SPMG_ST_ACTIVE;
        end else begin
            state_q <= state_d;
        end
    end

    // Mode is frozen at entry so later field writes cannot alter it
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            mode_q <= SPMG_MODE_IDLE;
        end else if (state_q == SPMG_ST_ACTIVE && sleep_req) begin
            mode_q <= mode_d;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            resume_q <= 1'b0;
        end else begin
            resume_q <= (state_q == SPMG_ST_HOLD) && hold_done;
        end
    end

    spmg_count #(
        .W        (`SPMG_CNT_W)
    ) u_start_cnt (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .load     (start_load),
        .load_val (osc_kept ? `SPMG_STBY_WAKE_CK : start_ck),
        .busy     (start_busy),
        .done     (start_done)
    );

    spmg_count #(
        .W        (`SPMG_CNT_W)
    ) u_hold_cnt (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .load     (hold_load),
        .load_val (`SPMG_HALT_EXTRA_CK),
        .busy     (),
        .done     (hold_done)
    );

    // Clock enables for the next state, registered so that all
    // gated domains switch on one edge.
    always_comb begin
        clk_d = '{cpu: 1'b1, flash: 1'b1, io: 1'b1, osc: 1'b1};
        unique case (state_d)
            SPMG_ST_ACTIVE: begin
                clk_d = '{cpu: 1'b1, flash: 1'b1, io: 1'b1, osc: 1'b1};
            end
            SPMG_ST_SLEEP: begin
                clk_d.cpu   = 1'b0;
                clk_d.flash = 1'b0;
                clk_d.io    = !deep_mode;
                clk_d.osc   = !deep_mode || osc_kept ||
                              debug_enable_fuse;
            end
            SPMG_ST_START: begin
                // Oscillator restarts, domains stay gated
                clk_d.cpu   = 1'b0;
                clk_d.flash = 1'b0;
                clk_d.io    = 1'b0;
                clk_d.osc   = 1'b1;
            end
            SPMG_ST_HOLD: begin
                clk_d.cpu   = 1'b0;
                clk_d.flash = 1'b1;
                clk_d.io    = 1'b1;
                clk_d.osc   = 1'b1;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            clk_q <= '{cpu: 1'b1, flash: 1'b1, io: 1'b1, osc: 1'b1};
        end else begin
            clk_q <= clk_d;
        end
    end

    // Sleep mode control register
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sleep_mode_select_q <= 3'h0;
            sleep_enable_bit_q  <= 1'b0;
        end else if (reg_wr && reg_addr == `SPMG_OFF_SMC) begin
            sleep_mode_select_q <=
                reg_wdata[`SPMG_SM_MSB:`SPMG_SM_LSB];
            sleep_enable_bit_q  <= reg_wdata[`SPMG_SE_BIT];
        end
    end

    // Power reduction registers hold their value across sleep,
    // so a gated peripheral resumes exactly where it stopped.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            power_reduction_low_q  <= `SPMG_RESET_BYTE;
            power_reduction_high_q <= `SPMG_RESET_BYTE;
        end else if (reg_wr) begin
            if (reg_addr == `SPMG_OFF_PR_LOW) begin
                power_reduction_low_q <= reg_wdata;
            end
            if (reg_addr == `SPMG_OFF_PR_HIGH) begin
                power_reduction_high_q <= reg_wdata;
            end
        end
    end

    assign pr_bits = {power_reduction_high_q, power_reduction_low_q};

    // Read data stand for exactly one cycle; unmapped reads zero
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rdata_q <= `SPMG_RESET_BYTE;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `SPMG_OFF_SMC:
                    rdata_q <= {4'h0, sleep_mode_select_q,
                                sleep_enable_bit_q};
                `SPMG_OFF_PR_LOW:  rdata_q <= power_reduction_low_q;
                `SPMG_OFF_PR_HIGH: rdata_q <= power_reduction_high_q;
                `SPMG_OFF_STATUS:
                    rdata_q <= {1'b0, start_busy, state_q,
                                1'b0, mode_q};
                default:           rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign reg_rdata = rdata_q;

    // Per-peripheral gating; works whenever the I/O clock runs,
    // i.e. in active and idle alike.
    assign periph_clk_en = {`SPMG_NUM_PERIPH{clk_q.io}} &
                           ~pr_bits;
    // Bus access to a gated peripheral is blocked; the peripheral
    // still holds its resources, which software must release.
    assign periph_io_en  = ~pr_bits;

    assign clk_en     = clk_q;
    assign cpu_halted = !clk_q.cpu;
    assign cpu_resume = resume_q;

    // Asynchronous helpers
    assign twi_run     = twi_enabled;
    assign wdt_run     = wdt_enabled;
    assign ext_int_run = 1'b1;
    assign bod_run     = (brownout_level_fuses != 3'h7);

    // Comparator follows its enable except from entry to resume of a non-idle sleep mode,
    // but a reference user keeps the reference alive.
    assign acmp_run = acmp_enabled &&
                      !((state_q != SPMG_ST_ACTIVE) &&
                        deep_mode);
    assign vref_en  = bod_run ||
                      (acmp_enabled && acmp_uses_vref);

    assign digital_in_en = clk_q.io;
    assign wake_in_en    = clk_q.io || wake_pins_armed;

endmodule : spmg_top

// ==== test/spmg_top_asserts.sv ====
// Port-level checker for the sleep and power gating controller
`timescale 1ns/100ps
`include "spmg_consts.svh"
module spmg_top_asserts
    import spmg_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    input wire logic        halt_exec,
    input wire logic [3:0]  clock_source_fuses,
    input wire logic [2:0]  brownout_level_fuses,
    input wire logic        debug_enable_fuse,
    input wire logic        twi_enabled,
    input wire logic        wdt_enabled,
    input wire logic        acmp_uses_vref,
    input wire logic        wake_pins_armed,
    input wire spmg_clk_s   clk_en,
    input wire logic [15:0] periph_clk_en,
    input wire logic [15:0] periph_io_en,
    input wire logic        cpu_halted,
    input wire logic        cpu_resume,
    input wire logic        twi_run,
    input wire logic        wdt_run,
    input wire logic        bod_run,
    input wire logic        acmp_run,
    input wire logic        vref_en,
    input wire logic        digital_in_en
);
    logic [3:0] smc_q;
    logic       go;
    logic       stby;
    logic       deep;
    logic       idle;

    // Shadow of the control byte, so mode decoding is judged independently
    always_ff @(posedge sys_clk) begin
        if (!rst_n)
            smc_q <= 4'h0;
        else if (reg_wr && reg_addr == `SPMG_OFF_SMC)
            smc_q <= reg_wdata[3:0];
    end
    assign go   = halt_exec && smc_q[0] && !cpu_halted;
    assign stby = smc_q[3:2] == 2'b11 && clock_source_fuses[3];
    assign deep = smc_q[3:1] inside {3'h2, 3'h3} ||
                  (smc_q[3:2] == 2'b11 && !clock_source_fuses[3]);
    assign idle = !stby && !deep;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_deep_clk_off: assert property (
        go && deep |=> clk_en == {3'b000, debug_enable_fuse})
        else $error("deep sleep clock enables wrong");
    a_stby_osc_on: assert property (
        go && stby |=> clk_en == 4'h1)
        else $error("standby clock enables wrong");
    a_idle_io_on: assert property (
        go && idle |=> clk_en == 4'h3)
        else $error("idle clock enables wrong");
    a_halt_no_se: assert property (
        halt_exec && !smc_q[0] && !cpu_halted |=> !cpu_halted)
        else $error("halt without enable slept");
    a_debug_osc: assert property (
        debug_enable_fuse |-> clk_en.osc)
        else $error("oscillator stopped with debug fuse");
    a_resume_pulse: assert property (
        cpu_resume |-> !cpu_halted ##1 !cpu_resume)
        else $error("resume pulse wrong");
    a_hold_four: assert property (
        cpu_resume |-> $past(cpu_halted, 4))
        else $error("resume came without four halted cycles");
    a_acmp_off: assert property (
        cpu_halted && !clk_en.osc |-> !acmp_run)
        else $error("comparator running in deep sleep");
    a_vref_need: assert property (
        vref_en |-> bod_run || acmp_uses_vref)
        else $error("reference on without a user");
    a_bod_on: assert property (
        brownout_level_fuses != 3'h7 |-> bod_run)
        else $error("brown-out detector stopped");
    a_wdt_on: assert property (
        wdt_enabled |-> wdt_run)
        else $error("watchdog stopped");
    a_twi_deep: assert property (
        twi_enabled && !clk_en.osc |-> twi_run)
        else $error("serial interface stopped in deep sleep");
    a_gate_io: assert property (
        periph_clk_en == (clk_en.io ? periph_io_en : 16'h0000))
        else $error("peripheral clock gating wrong");
    a_din_off: assert property (
        !clk_en.osc && !wake_pins_armed |-> !digital_in_en)
        else $error("input buffers on in deep sleep");
    a_rd_upper: assert property (
        reg_rd && reg_addr == `SPMG_OFF_SMC |=> reg_rdata[7:4] == 4'h0)
        else $error("control byte upper bits not zero");
    a_reset_wake: assert property (disable iff (1'b0)
        !rst_n |=> !cpu_halted && clk_en == 4'hf)
        else $error("reset did not wake");

    c_deep: cover property (go && deep);
    c_stby: cover property (go && stby);
    c_resume: cover property (cpu_resume);
endmodule : spmg_top_asserts

bind spmg_top spmg_top_asserts u_chk (.*);

// ==== test/spmg_cpu_model.sv ====
// Behavioural CPU core that issues the halt instruction on request
`timescale 1ns/100ps
module spmg_cpu_model (
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       fire,
    input  wire logic [3:0] slow,
    input  wire logic       cpu_halted,
    output logic            halt_exec
);
    logic [3:0] wait_q;
    logic       pend_q;

    // A halted core cannot execute, so the pulse waits for it to run
    always_ff @(posedge sys_clk) begin
        halt_exec <= 1'b0;
        if (!rst_n) begin
            pend_q <= 1'b0;
            wait_q <= 4'h0;
        end else if (fire) begin
            pend_q <= 1'b1;
            wait_q <= slow;
        end else if (pend_q && wait_q != 4'h0) begin
            wait_q <= wait_q - 4'h1;
        end else if (pend_q && !cpu_halted) begin
            halt_exec <= 1'b1;
            pend_q    <= 1'b0;
        end
    end
endmodule : spmg_cpu_model

// ==== test/test_sleep_mode_power_gating.sv ====
// Self-checking bench for the sleep and power gating controller
`timescale 1ns/100ps
`include "spmg_consts.svh"
module test_sleep_mode_power_gating
    import spmg_pkg::*;
;
    logic sys_clk, rst_n, reg_wr, reg_rd, halt_exec, fire;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    spmg_wake_s wake_in;
    logic [3:0] clock_source_fuses, slow;
    logic [2:0] brownout_level_fuses;
    logic debug_enable_fuse, twi_enabled, wdt_enabled, acmp_enabled;
    logic acmp_uses_vref, wake_pins_armed;
    spmg_clk_s clk_en;
    logic [15:0] periph_clk_en, periph_io_en;
    logic cpu_halted, cpu_resume, twi_run, wdt_run, ext_int_run, bod_run;
    logic acmp_run, vref_en, digital_in_en, wake_in_en;
    int fails, comparisons, cycles;

    spmg_top dut (.*);
    spmg_cpu_model u_cpu (.sys_clk(sys_clk), .rst_n(rst_n), .fire(fire),
        .slow(slow), .cpu_halted(cpu_halted), .halt_exec(halt_exec));

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    // Longest path is just under a hundred cycles per test
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            summarize();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    function automatic spmg_wake_s wsrc(input int k);
        spmg_wake_s w;
        w = '0;
        case (k)
            0: w.any_enabled_irq = 1'b1;
            1: w.twi_addr_match = 1'b1;
            2: w.usb_async_wakeup_irq = 1'b1;
            3: w.pin_change_irq = 1'b1;
            4: w.lower_external_irqs = 4'h8;
            5: w = '{upper_external_irqs: 4'h4, upper_level_mode: 4'h4,
                     default: '0};
            default: w.wdt_irq = 1'b1;
        endcase
        return w;
    endfunction : wsrc

    task automatic t_regs;
        logic [7:0] d;
        rd(`SPMG_OFF_SMC, d);
        chk(d, `SPMG_RESET_BYTE);
        wr(`SPMG_OFF_SMC, 8'hff);
        rd(`SPMG_OFF_SMC, d);
        chk(d, 8'h0f);
        wr(8'h10, 8'h5a);
        rd(8'h10, d);
        chk(d, 8'h00);
        wr(`SPMG_OFF_SMC, 8'h00);
        $display("test regs done");
    endtask : t_regs

    task automatic t_gate;
        logic [7:0] d;
        wr(`SPMG_OFF_PR_LOW, 8'ha5);
        wr(`SPMG_OFF_PR_HIGH, 8'h3c);
        rd(`SPMG_OFF_PR_HIGH, d);
        chk(d, 8'h3c);
        chk(periph_io_en, 16'hc35a);
        chk(periph_clk_en, 16'hc35a);
        wr(`SPMG_OFF_PR_LOW, 8'h00);
        wr(`SPMG_OFF_PR_HIGH, 8'h00);
        #1 chk(periph_clk_en, 16'hffff);
        $display("test gate done");
    endtask : t_gate

    task automatic t_ana;
        acmp_enabled <= 1'b1;
        @(posedge sys_clk);
        #1 chk(vref_en, 1'b0);
        brownout_level_fuses <= 3'h2;
        @(posedge sys_clk);
        #1 chk({vref_en, bod_run}, 2'h3);
        acmp_uses_vref <= 1'b1;
        brownout_level_fuses <= 3'h7;
        @(posedge sys_clk);
        #1 chk(vref_en, 1'b1);
        $display("test analog done");
    endtask : t_ana

    task automatic t_sleep(input logic [2:0] m, input logic [3:0] fz,
                           input logic dbg, input logic [3:0] ck,
                           input int src, input int lo, input int hi);
        int n;
        clock_source_fuses <= fz;
        debug_enable_fuse  <= dbg;
        wake_pins_armed    <= (src != 1);
        wr(`SPMG_OFF_SMC, {4'h0, m, 1'b1});
        fire <= 1'b1;
        @(posedge sys_clk);
        fire <= 1'b0;
        n = 0;
        do begin
            @(posedge sys_clk);
            #1 n++;
        end while (!cpu_halted && n < 40);
        chk(clk_en, ck);
        chk(acmp_run, ck[1]);
        chk({twi_run, wdt_run, ext_int_run}, 3'h7);
        chk({digital_in_en, wake_in_en}, {ck[1], ck[1] || src != 1});
        if (!ck[1]) begin
            wake_in.upper_external_irqs <= 4'h2;
            repeat (20) @(posedge sys_clk);
            #1 chk(cpu_halted, 1'b1);
        end
        wake_in <= wsrc(src);
        n = 0;
        do begin
            @(posedge sys_clk);
            #1 n++;
        end while (!cpu_resume && n < 3000);
        chk(n >= lo && n <= hi, 1'b1);
        chk(clk_en, 4'hf);
        wake_in <= '0;
        wr(`SPMG_OFF_SMC, 8'h00);
        $display("test sleep mode %0d done", m);
    endtask : t_sleep

    task automatic t_nose;
        wr(`SPMG_OFF_SMC, 8'h04);
        fire <= 1'b1;
        @(posedge sys_clk);
        fire <= 1'b0;
        repeat (6) @(posedge sys_clk);
        #1 chk({clk_en, cpu_halted}, 5'h1e);
        $display("test no enable done");
    endtask : t_nose

    task automatic t_rst;
        logic [7:0] d;
        slow <= 4'h5;
        wr(`SPMG_OFF_SMC, 8'h05);
        fire <= 1'b1;
        @(posedge sys_clk);
        fire <= 1'b0;
        repeat (12) @(posedge sys_clk);
        #1 chk(cpu_halted, 1'b1);
        @(posedge sys_clk);
        rst_n <= 1'b0;
        @(posedge sys_clk);
        rst_n <= 1'b1;
        #1 chk({clk_en, cpu_halted}, 5'h1e);
        rd(`SPMG_OFF_SMC, d);
        chk(d, 8'h00);
        $display("test reset in sleep done");
    endtask : t_rst

    task automatic summarize;
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : summarize

    initial begin
        {rst_n, reg_wr, reg_rd, fire, debug_enable_fuse} = 5'h0;
        {reg_addr, reg_wdata, slow, clock_source_fuses} = 24'h0;
        {acmp_enabled, acmp_uses_vref} = 2'h0;
        {twi_enabled, wdt_enabled, wake_pins_armed} = 3'h7;
        brownout_level_fuses = 3'h7;
        wake_in = '0;
        {fails, comparisons} = '0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_regs();
        t_gate();
        t_ana();
        t_nose();
        // Wake edge counts: one to see the source, start count, four held
        t_sleep(3'h0, 4'h0, 1'b0, 4'h3, 0, 5, 5);
        t_sleep(3'h1, 4'h0, 1'b0, 4'h3, 0, 5, 5);
        t_sleep(3'h4, 4'h0, 1'b0, 4'h3, 6, 5, 5);
        t_sleep(3'h5, 4'h0, 1'b0, 4'h3, 3, 5, 5);
        t_sleep(3'h2, 4'h0, 1'b0, 4'h0, 1, 21, 21);
        t_sleep(3'h3, 4'h1, 1'b0, 4'h0, 2, 69, 69);
        t_sleep(3'h6, 4'h8, 1'b0, 4'h1, 4, 11, 11);
        t_sleep(3'h7, 4'h8, 1'b0, 4'h1, 5, 11, 11);
        t_sleep(3'h6, 4'h0, 1'b0, 4'h0, 3, 21, 21);
        t_sleep(3'h2, 4'h0, 1'b1, 4'h1, 4, 21, 21);
        t_rst();
        summarize();
    end
endmodule : test_sleep_mode_power_gating
